// [rtl/lmc_pkg.sv]
package lmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  // wake_filter_time, least dominant time for a valid bus wake-up
  localparam int WAKE_FILTER_NS = 30000;
  // init_timeout, longest stay in init unless supply ok and mode select are both seen
  localparam int INIT_TIMEOUT_US = 150000;
  // reset release delay after the supply passes supply_undervoltage_on_threshold
  localparam int RST_DELAY_US = 10000;

  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WAKE_FILTER_CYC = ceil_cycles(WAKE_FILTER_NS);
  localparam int INIT_TIMEOUT_CYC = (INIT_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int RST_DELAY_CYC = ceil_cycles(RST_DELAY_US * 1000);

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_EVENT = 4'h8;

  localparam int CTRL_WAKE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_REG_EN_BIT = 4;
  localparam int STAT_HRST_N_BIT = 5;
  localparam int STAT_VCC_OK_BIT = 6;
  localparam int STAT_RXD_BIT = 7;

  localparam int EVT_WAKE_BIT = 0;
  localparam int EVT_TIMEOUT_BIT = 1;
  localparam int EVT_SUPPLY_BIT = 2;
  localparam int EVT_W = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // operating modes
  typedef enum logic [3:0] {
    LMC_SLEEP = 4'h1,
    LMC_INIT = 4'h2,
    LMC_STBY = 4'h4,
    LMC_NORMAL = 4'h8
  } lmc_mode_e;

endpackage

// [rtl/lmc_pin_if.sv]
`timescale 1ns/1ps
interface lmc_pin_if;
  logic mode_sel;
  logic txd;
  logic bus_dom;
  logic ms_rise;
  logic ms_fall;
  logic wake;
  logic wake_arm;

  modport cond (output mode_sel, output txd, output bus_dom, output ms_rise, output ms_fall, output wake,
                input wake_arm);
  modport ctrl (input mode_sel, input txd, input bus_dom, input ms_rise, input ms_fall, input wake,
                output wake_arm);
endinterface

// [rtl/lmc_pin_cond.sv]
`timescale 1ns/1ps
module lmc_pin_cond
  import lmc_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_FILTER_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mode_sel_i,
  input wire logic txd_i,
  input wire logic bus_rx_i,
  lmc_pin_if.cond pin
);
  localparam int CW = $clog2(WAKE_CYC + 1);
  localparam logic [CW-1:0] WAKE_LIM = CW'(WAKE_CYC);

  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic ms_d_r;
  logic [CW-1:0] dom_cnt_r;
  logic qual_r;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers: mode select, transmit data, bus level
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      // idle levels: bus recessive, transmit high, select low, so no false edge follows reset
      meta_r <= 3'h6;
      sync_r <= 3'h6;
    end else begin
      meta_r <= {bus_rx_i, txd_i, mode_sel_i};
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ms_d_r <= 1'b0;
    end else begin
      ms_d_r <= sync_r[0];
    end
  end

  assign pin.mode_sel = sync_r[0];
  assign pin.txd = sync_r[1];
  assign pin.bus_dom = ~sync_r[2];
  assign pin.ms_rise = sync_r[0] & ~ms_d_r;
  assign pin.ms_fall = ~sync_r[0] & ms_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // wake filter: dominant longer than the filter time, reported on return to recessive
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !pin.wake_arm || !pin.bus_dom) begin
      dom_cnt_r <= '0;
    end else if (dom_cnt_r != WAKE_LIM) begin
      dom_cnt_r <= dom_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !pin.wake_arm) begin
      qual_r <= 1'b0;
    end else if (pin.bus_dom) begin
      qual_r <= (dom_cnt_r == WAKE_LIM);
    end else begin
      qual_r <= 1'b0;
    end
  end

  assign pin.wake = qual_r & ~pin.bus_dom & pin.wake_arm;
endmodule

// [rtl/lmc_mode_ctrl.sv]
// How it works
// - normal mode: transmit low drives bus dominant
// - normal mode: receive output mirrors bus level
// - stand-by entered only from normal mode
// - stand-by: regulator on, receive low on wake
// - power-up starts in init, regulator running
// - init timeout without mode select goes sleep
// - supply and thermal events force init mode
// - sleep still detects bus wake, enters init
// - wake counts only after filtered dominant time
// - sleep entry: select low with transmit low
// - sleep entry ignores a stuck dominant bus
// - wake into init drives receive output low
// - init after power-up keeps receive high
// - wake acts when bus returns recessive
// - reset release waits supply stable delay
// - select fall picks sleep or stand-by
// - leaving normal: transmitter off, receive high
// - sleep: regulator off, discharged; stand-by keeps it
// - sleep left by select high into init
// - init to normal after supply ok, delay
// - normal mode enables transmitter and echo
// - host reset low in undervoltage and sleep
// - stand-by select rise goes straight normal
// - init watchdog cancelled only once supply ok and mode select both seen in init
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module lmc_mode_ctrl
  import lmc_pkg::*;
#(
  parameter int INIT_TMO_CYC = INIT_TIMEOUT_CYC,
  parameter int RST_DLY_CYC = RST_DELAY_CYC,
  parameter int WAKE_CYC = WAKE_FILTER_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // host side pins
  input wire logic mode_sel_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic host_reset_out_n_o,
  // bus side
  input wire logic bus_rx_i,
  output logic bus_tx_dom_o,
  // supply and regulator
  input wire logic vcc_above_uv_i,
  input wire logic power_up_i,
  input wire logic supply_por_i,
  input wire logic supply_uv_fail_i,
  input wire logic overtemp_recover_i,
  output logic reg_en_o,
  output logic vcc_discharge_o
);
  localparam int TW = $clog2(INIT_TMO_CYC + 1);
  localparam int RW = $clog2(RST_DLY_CYC + 1);
  localparam logic [TW-1:0] TMO_LIM = TW'(INIT_TMO_CYC);
  localparam logic [RW-1:0] RST_LIM = RW'(RST_DLY_CYC);

  lmc_pin_if pin ();

  lmc_mode_e state_r;
  lmc_mode_e state_nxt;
  logic wake_lo_r;
  logic wake_lo_nxt;
  logic [TW-1:0] tmo_cnt_r;
  logic sup_ok_seen_r;
  logic en_seen_r;
  logic [RW-1:0] rst_cnt_r;
  logic vcc_stable;
  logic tmo_hit;
  logic supply_evt;
  logic [31:0] ctrl_r;
  logic [EVT_W-1:0] evt_r;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic acc_wr;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  lmc_pin_cond #(
    .WAKE_CYC(WAKE_CYC)
  ) u_cond (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .mode_sel_i(mode_sel_i),
    .txd_i(txd_i),
    .bus_rx_i(bus_rx_i),
    .pin(pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wake detection armed only while asleep or in stand-by
  assign pin.wake_arm = ctrl_r[CTRL_WAKE_EN_BIT] &&
                        ((state_r == LMC_SLEEP) || (state_r == LMC_STBY));

  assign supply_evt = power_up_i | supply_por_i | supply_uv_fail_i | overtemp_recover_i;
  assign vcc_stable = (rst_cnt_r == RST_LIM);
  assign tmo_hit = (state_r == LMC_INIT) && (tmo_cnt_r == TMO_LIM);

  ////////////////////////////////////////////////////////////////////////////
  // mode decisions
  always_comb begin
    state_nxt = state_r;
    wake_lo_nxt = wake_lo_r;
    if (supply_evt) begin
      state_nxt = LMC_INIT;
      wake_lo_nxt = 1'b0;
    end else begin
      case (state_r)
        LMC_NORMAL: begin
          wake_lo_nxt = 1'b0;
          if (pin.ms_fall) begin
            // bus level plays no part, so a shorted bus cannot block sleep
            state_nxt = pin.txd ? LMC_STBY : LMC_SLEEP;
          end
        end
        LMC_STBY: begin
          if (pin.ms_rise) begin
            state_nxt = LMC_NORMAL;
            wake_lo_nxt = 1'b0;
          end else if (pin.wake) begin
            state_nxt = LMC_INIT;
            wake_lo_nxt = 1'b1;
          end
        end
        LMC_SLEEP: begin
          if (pin.wake) begin
            state_nxt = LMC_INIT;
            wake_lo_nxt = 1'b1;
          end else if (pin.mode_sel) begin
            state_nxt = LMC_INIT;
            wake_lo_nxt = 1'b0;
          end
        end
        LMC_INIT: begin
          if (pin.mode_sel && vcc_stable) begin
            state_nxt = LMC_NORMAL;
            wake_lo_nxt = 1'b0;
          end else if (tmo_hit && (!en_seen_r || !sup_ok_seen_r)) begin
            state_nxt = LMC_SLEEP;
            wake_lo_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt = LMC_INIT;
          wake_lo_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= LMC_INIT;
      wake_lo_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wake_lo_r <= wake_lo_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // init watchdog, restarted on every entry into init
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || (state_nxt == LMC_INIT && state_r != LMC_INIT) || supply_evt) begin
      tmo_cnt_r <= '0;
    end else if (state_r == LMC_INIT && tmo_cnt_r != TMO_LIM) begin
      tmo_cnt_r <= tmo_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || (state_nxt == LMC_INIT && state_r != LMC_INIT) || supply_evt) begin
      sup_ok_seen_r <= 1'b0;
    end else if (state_r == LMC_INIT && vcc_above_uv_i) begin
      sup_ok_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || (state_nxt == LMC_INIT && state_r != LMC_INIT) || supply_evt) begin
      en_seen_r <= 1'b0;
    end else if (state_r == LMC_INIT && pin.mode_sel) begin
      en_seen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply stable delay, restarts on any undervoltage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !vcc_above_uv_i || !reg_en_o) begin
      rst_cnt_r <= '0;
    end else if (!vcc_stable) begin
      rst_cnt_r <= rst_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, taken from the next mode so leaving normal acts at once
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_tx_dom_o <= 1'b0;
    end else begin
      bus_tx_dom_o <= (state_nxt == LMC_NORMAL) && !pin.txd;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rxd_o <= 1'b1;
      rxd_oe_o <= 1'b1;
    end else begin
      rxd_oe_o <= (state_nxt != LMC_SLEEP);
      case (state_nxt)
        LMC_NORMAL: rxd_o <= !pin.bus_dom;
        LMC_INIT: rxd_o <= !wake_lo_nxt;
        default: rxd_o <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_en_o <= 1'b1;
      vcc_discharge_o <= 1'b0;
    end else begin
      reg_en_o <= (state_nxt != LMC_SLEEP);
      vcc_discharge_o <= (state_nxt == LMC_SLEEP);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      host_reset_out_n_o <= 1'b0;
    end else begin
      host_reset_out_n_o <= vcc_stable && vcc_above_uv_i && (state_nxt != LMC_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: waitrequest drops one cycle after the request is seen
  assign acc_wr = avs_write_i && !waitreq_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      waitreq_r <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && waitreq_r) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  assign avs_waitrequest_o = waitreq_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (acc_wr && avs_address_i == REG_CTRL) begin
      ctrl_r <= be_merge(ctrl_r, avs_writedata_i, avs_byteenable_i) & CTRL_RESET;
    end
  end

  // sticky events; a new event in the clearing cycle stays set
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      evt_r <= EVT_RESET;
    end else begin
      if (acc_wr && avs_address_i == REG_EVENT && avs_byteenable_i[0]) begin
        evt_r <= (evt_r & ~avs_writedata_i[EVT_W-1:0]) |
                 {supply_evt, tmo_hit && (state_nxt == LMC_SLEEP), pin.wake};
      end else begin
        evt_r <= evt_r | {supply_evt, tmo_hit && (state_nxt == LMC_SLEEP), pin.wake};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i && waitreq_r) begin
      case (avs_address_i)
        REG_CTRL: rdata_r <= ctrl_r;
        REG_STATUS: begin
          rdata_r <= 32'h0000_0000;
          rdata_r[STAT_MODE_LSB +: 4] <= state_r;
          rdata_r[STAT_REG_EN_BIT] <= reg_en_o;
          rdata_r[STAT_HRST_N_BIT] <= host_reset_out_n_o;
          rdata_r[STAT_VCC_OK_BIT] <= vcc_stable;
          rdata_r[STAT_RXD_BIT] <= rxd_o;
        end
        REG_EVENT: rdata_r <= {{(32-EVT_W){1'b0}}, evt_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_o = rdata_r;
endmodule

// [verification/lmc_far_model.sv]
`timescale 1ns/1ps
module lmc_far_model #(
  parameter int RAMP_CYC = 6
) (
  input wire logic clk_sys_i,
  input wire logic bus_tx_dom_i,
  input wire logic remote_dom_i,
  input wire logic reg_en_i,
  input wire logic vcc_fail_i,
  output logic bus_rx_o,
  output logic vcc_ok_o
);
  int ramp_r;
  // wired-and bus with pull-up: dominant while any node pulls it down
  assign bus_rx_o = !(bus_tx_dom_i === 1'b1 || remote_dom_i === 1'b1);
  // regulator output needs some cycles to ramp, collapses at once when off
  always_ff @(posedge clk_sys_i) begin
    if (reg_en_i !== 1'b1) begin
      ramp_r <= 0;
    end else if (ramp_r < RAMP_CYC) begin
      ramp_r <= ramp_r + 1;
    end
  end
  assign vcc_ok_o = (ramp_r >= RAMP_CYC) && (vcc_fail_i !== 1'b1);
endmodule

// [verification/lmc_mode_ctrl_properties.sv]
`timescale 1ns/1ps
module lmc_mode_ctrl_properties #(
  parameter int RST_DLY_CYC = 20
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mode_sel_i,
  input wire logic txd_i,
  input wire logic vcc_above_uv_i,
  input wire logic power_up_i,
  input wire logic supply_por_i,
  input wire logic supply_uv_fail_i,
  input wire logic overtemp_recover_i,
  input wire logic rxd_o,
  input wire logic host_reset_out_n_o,
  input wire logic bus_tx_dom_o,
  input wire logic reg_en_o,
  input wire logic vcc_discharge_o
);
  logic [31:0] vcc_cnt_r;
  logic [3:0] ms_low_r;
  logic any_evt;
  assign any_evt = power_up_i | supply_por_i | supply_uv_fail_i | overtemp_recover_i;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // cycles of unbroken good supply, cycles of mode select low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !vcc_above_uv_i) begin
      vcc_cnt_r <= 32'h0;
    end else if (vcc_cnt_r != 32'hFFFFFFFF) begin
      vcc_cnt_r <= vcc_cnt_r + 32'h1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || mode_sel_i) begin
      ms_low_r <= 4'h0;
    end else if (ms_low_r != 4'hF) begin
      ms_low_r <= ms_low_r + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_tx_txd; bus_tx_dom_o |-> !$past(txd_i, 2) || !$past(txd_i, 3) || !$past(txd_i, 4) || !$past(txd_i, 5); endproperty
  a_tx_txd: assert property (p_tx_txd) else $error("bus dominant without transmit low");
  property p_rxd_echo; bus_tx_dom_o [*6] |-> !rxd_o; endproperty
  a_rxd_echo: assert property (p_rxd_echo) else $error("receive output misses dominant bus");
  property p_tx_on; bus_tx_dom_o |-> reg_en_o && !vcc_discharge_o; endproperty
  a_tx_on: assert property (p_tx_on) else $error("transmitter active outside normal mode");
  property p_sel_low; ms_low_r >= 4'h6 |-> !bus_tx_dom_o; endproperty
  a_sel_low: assert property (p_sel_low) else $error("transmitter still on after select low");
  property p_sleep; vcc_discharge_o && $past(vcc_discharge_o) |-> !reg_en_o && !host_reset_out_n_o; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_reg_off; !reg_en_o |-> vcc_discharge_o; endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator off without discharge");
  property p_uv_low; !vcc_above_uv_i |=> !host_reset_out_n_o; endproperty
  a_uv_low: assert property (p_uv_low) else $error("host reset high in undervoltage");
  property p_rst_dly; $rose(host_reset_out_n_o) |-> vcc_cnt_r >= RST_DLY_CYC - 1; endproperty
  a_rst_dly: assert property (p_rst_dly) else $error("host reset released too early");
  property p_evt; any_evt |-> ##[1:3] (reg_en_o && !bus_tx_dom_o && !vcc_discharge_o); endproperty
  a_evt: assert property (p_evt) else $error("supply event did not force init");
endmodule

bind lmc_mode_ctrl lmc_mode_ctrl_properties #(.RST_DLY_CYC(RST_DLY_CYC)) lmc_mode_ctrl_properties_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_sel_i(mode_sel_i), .txd_i(txd_i),
  .vcc_above_uv_i(vcc_above_uv_i), .power_up_i(power_up_i), .supply_por_i(supply_por_i),
  .supply_uv_fail_i(supply_uv_fail_i), .overtemp_recover_i(overtemp_recover_i), .rxd_o(rxd_o),
  .host_reset_out_n_o(host_reset_out_n_o), .bus_tx_dom_o(bus_tx_dom_o), .reg_en_o(reg_en_o),
  .vcc_discharge_o(vcc_discharge_o));

// [verification/lmc_mode_ctrl_tb.sv]
`timescale 1ns/1ps
module lmc_mode_ctrl_tb;
  import lmc_pkg::*;
  localparam int TMO = 200;
  localparam int RST_DLY = 20;
  localparam int WAKE = 8;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
  logic clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, mode_sel_i, txd_i, remote_dom, vcc_fail;
  logic rxd_o, rxd_oe_o, host_reset_out_n_o, bus_rx_i, bus_tx_dom_o, vcc_above_uv_i, reg_en_o, vcc_discharge_o;
  logic [3:0] avs_address_i, evt;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  int bad_count, compares;
  lmc_mode_ctrl #(.INIT_TMO_CYC(TMO), .RST_DLY_CYC(RST_DLY), .WAKE_CYC(WAKE)) lmc_mode_ctrl_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .mode_sel_i(mode_sel_i),
    .txd_i(txd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .host_reset_out_n_o(host_reset_out_n_o), .bus_rx_i(bus_rx_i),
    .bus_tx_dom_o(bus_tx_dom_o), .vcc_above_uv_i(vcc_above_uv_i), .power_up_i(evt[0]), .supply_por_i(evt[1]),
    .supply_uv_fail_i(evt[2]), .overtemp_recover_i(evt[3]), .reg_en_o(reg_en_o), .vcc_discharge_o(vcc_discharge_o));
  lmc_far_model #(.RAMP_CYC(6)) lmc_far_model_inst (
    .clk_sys_i(clk_sys_i), .bus_tx_dom_i(bus_tx_dom_o), .remote_dom_i(remote_dom), .reg_en_i(reg_en_o),
    .vcc_fail_i(vcc_fail), .bus_rx_o(bus_rx_i), .vcc_ok_o(vcc_above_uv_i));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic mode_is(input lmc_mode_e e);
    av_xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[3:0], e)
  endtask
  task automatic wait_mode(input lmc_mode_e e, input int n);
    repeat (n) begin
      av_xfer(1'b0, REG_STATUS, 32'h0);
      if (rd[3:0] === e) break;
    end
    `CHK(rd[3:0], e)
  endtask
  task automatic stop_test;
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    step(6000);
    bad_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i <= 1'b1;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    avs_address_i <= 4'h0;
    avs_writedata_i <= 32'h0;
    mode_sel_i <= 1'b0;
    txd_i <= 1'b1;
    remote_dom <= 1'b0;
    vcc_fail <= 1'b0;
    evt <= 4'h0;
    step(6);
    rst_i <= 1'b0;
    step(1);
    `CHK(reg_en_o, 1'b1)
    `CHK(bus_tx_dom_o, 1'b0)
    `CHK(rxd_o, 1'b1)
    `CHK(host_reset_out_n_o, 1'b0)
    mode_is(LMC_INIT);
    av_xfer(1'b0, REG_CTRL, 32'h0);
    `CHK(rd, CTRL_RESET)
    av_xfer(1'b1, 4'hC, 32'hFFFFFFFF);
    av_xfer(1'b0, 4'hC, 32'h0);
    `CHK(rd, 32'h0)
    mode_sel_i <= 1'b1;
    wait_mode(LMC_NORMAL, 30);
    `CHK(host_reset_out_n_o, 1'b1)
    txd_i <= 1'b0;
    step(8);
    `CHK(bus_tx_dom_o, 1'b1)
    `CHK(rxd_o, 1'b0)
    txd_i <= 1'b1;
    step(8);
    `CHK(bus_tx_dom_o, 1'b0)
    `CHK(rxd_o, 1'b1)
    remote_dom <= 1'b1;
    step(8);
    `CHK(rxd_o, 1'b0)
    remote_dom <= 1'b0;
    mode_sel_i <= 1'b0;
    step(8);
    mode_is(LMC_STBY);
    `CHK(reg_en_o, 1'b1)
    `CHK(rxd_o, 1'b1)
    remote_dom <= 1'b1;
    step(WAKE / 2);
    remote_dom <= 1'b0;
    step(8);
    mode_is(LMC_STBY);
    remote_dom <= 1'b1;
    step(WAKE + 6);
    `CHK(rxd_o, 1'b1)
    remote_dom <= 1'b0;
    step(6);
    mode_is(LMC_INIT);
    `CHK(rxd_o, 1'b0)
    av_xfer(1'b0, REG_EVENT, 32'h0);
    `CHK(rd[EVT_WAKE_BIT], 1'b1)
    av_xfer(1'b1, REG_EVENT, 32'h1);
    av_xfer(1'b0, REG_EVENT, 32'h0);
    `CHK(rd[EVT_WAKE_BIT], 1'b0)
    mode_sel_i <= 1'b1;
    wait_mode(LMC_NORMAL, 30);
    mode_sel_i <= 1'b0;
    step(8);
    mode_is(LMC_STBY);
    mode_sel_i <= 1'b1;
    step(8);
    mode_is(LMC_NORMAL);
    remote_dom <= 1'b1;
    txd_i <= 1'b0;
    step(8);
    mode_sel_i <= 1'b0;
    step(5);
    `CHK(vcc_discharge_o, 1'b1)
    `CHK(bus_tx_dom_o, 1'b0)
    mode_is(LMC_SLEEP);
    `CHK(reg_en_o, 1'b0)
    `CHK(host_reset_out_n_o, 1'b0)
    `CHK(rxd_oe_o, 1'b0)
    step(WAKE + 4);
    remote_dom <= 1'b0;
    step(6);
    mode_is(LMC_INIT);
    `CHK(rxd_o, 1'b0)
    `CHK(reg_en_o, 1'b1)
    txd_i <= 1'b1;
    wait_mode(LMC_SLEEP, 120);
    mode_sel_i <= 1'b1;
    step(6);
    mode_is(LMC_INIT);
    `CHK(reg_en_o, 1'b1)
    wait_mode(LMC_NORMAL, 30);
    for (int i = 0; i < 4; i++) begin
      evt <= 4'(1 << i);
      step(3);
      mode_is(LMC_INIT);
      evt <= 4'h0;
      wait_mode(LMC_NORMAL, 30);
    end
    vcc_fail <= 1'b1;
    step(3);
    `CHK(host_reset_out_n_o, 1'b0)
    vcc_fail <= 1'b0;
    step(RST_DLY + 15);
    `CHK(host_reset_out_n_o, 1'b1)
    stop_test();
  end
endmodule
